// *** core/special_regs_pkg.sv ***
// package for the processor special register set
package special_regs_pkg;

  // register indices on the plain register port
  localparam logic [3:0] REG_CONDITION_CODES = 4'h0;
  localparam logic [3:0] REG_VECTOR_TABLE_BASE = 4'h1;
  localparam logic [3:0] REG_RETURN_LINK = 4'h2;
  localparam logic [3:0] REG_SYSTEM_STACK_POINTER = 4'h3;
  localparam logic [3:0] REG_USER_STACK_POINTER = 4'h4;
  localparam logic [3:0] REG_MULDIV_HIGH_WORD = 4'h5;
  localparam logic [3:0] REG_MULDIV_LOW_WORD = 4'h6;
  localparam logic [3:0] REG_ACTIVE_STACK = 4'h7;
  localparam int ADDR_W = 4;

  // condition code field positions
  localparam int CC_STACK_SELECT = 5;
  localparam int CC_INT_ENABLE = 4;
  localparam int CC_NEGATIVE = 3;
  localparam int CC_ZERO = 2;
  localparam int CC_OVERFLOW = 1;
  localparam int CC_CARRY = 0;
  localparam logic [7:0] CC_WRITE_MASK = 8'h3f;

  localparam logic [31:0] VECTOR_TABLE_BASE_RESET = 32'h000f_fc00;
  localparam logic [31:0] SYSTEM_STACK_POINTER_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [31:0] CALL_STEP_DELAY_SLOT = 32'h0000_0004;
  localparam logic [31:0] CALL_STEP_NO_SLOT = 32'h0000_0002;
  localparam logic [31:0] STACK_WORD = 32'h0000_0004;

  // flag update from the execution unit
  typedef struct packed {
    logic update_nz;
    logic update_v;
    logic update_c;
    logic [31:0] result;
    logic overflow;
    logic carry;
  } flag_update_t;

  // call request
  typedef struct packed {
    logic call;
    logic delay_slot;
    logic [31:0] call_address;
  } call_req_t;

  // stack pointer adjust through the indirect stack register
  typedef struct packed {
    logic push;
    logic pop;
  } stack_req_t;

  // multiply / divide result load
  typedef struct packed {
    logic load_product;
    logic [63:0] product;
    logic load_divide;
    logic [31:0] remainder;
    logic [31:0] quotient;
  } muldiv_req_t;

  // event entry: vector fetch and save onto system stack
  typedef struct packed {
    logic take;
    logic [9:0] vector_offset;
  } event_req_t;

endpackage : special_regs_pkg

// *** core/special_regs.sv ***
// processor special register set: condition codes, vector base, links, stacks, muldiv
//Contract
// (RULE_01) condition codes: stack select bit5, int enable bit4, n z v c bits3..0.
// (RULE_02) stack select 0 picks system stack pointer, 1 picks user pointer.
// (RULE_03) return from event only executed while stack select is 0.
// (RULE_04) interrupt enable 0 blocks interrupt acceptance, 1 allows it.
// (RULE_05) negative flag follows sign bit of the result.
// (RULE_06) zero flag set when result is zero, cleared otherwise.
// (RULE_07) overflow flag records two's complement overflow of the result.
// (RULE_08) carry flag records carry out or borrow of the top bit.
// (RULE_09) shifts load carry with the last bit shifted out.
// (RULE_10) reset clears stack select and interrupt enable; other flags undefined.
// (RULE_11) interrupt enabling status write may land first, re-executes identically.
// (RULE_12) divide step bits may update before an event, re-execute identically.
// (RULE_13) vector address is vector table base plus event vector offset.
// (RULE_14) low two bits of the vector address are forced to zero.
// (RULE_15) vector table base resets to 000ffc00.
// (RULE_16) software keeps vector table base at or below fffffc00.
// (RULE_17) call loads return link with address plus 4 or plus 2.
// (RULE_18) return link is a single unstacked register, reset undefined.
// (RULE_19) events save state via the system stack pointer regardless of select.
// (RULE_20) indirect stack pushes pre-decrement, pops post-increment, selected pointer.
// (RULE_21) system stack pointer resets to zero; user pointer undefined.
// (RULE_22) multiply stores full 64-bit product, high and low words.
// (RULE_23) divide leaves remainder in high word, quotient in low word.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module special_regs
  import special_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [special_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire special_regs_pkg::flag_update_t flag_update,
  input wire special_regs_pkg::call_req_t call_req,
  input wire logic return_from_call,
  input wire special_regs_pkg::stack_req_t stack_req,
  input wire special_regs_pkg::event_req_t event_req,
  input wire special_regs_pkg::muldiv_req_t muldiv_req,
  output logic [7:0] condition_codes,
  output logic [31:0] vector_fetch_address,
  output logic [31:0] event_save_address,
  output logic [31:0] active_stack_pointer,
  output logic [31:0] return_target,
  output logic [63:0] muldiv_result,
  output logic interrupts_enabled,
  output logic return_from_event_allowed
);
  import special_regs_pkg::*;

  logic [7:0] cc_q, cc_d;
  logic [31:0] vtb_q, vtb_d;
  logic [31:0] link_q, link_d;
  logic [31:0] ssp_q, ssp_d;
  logic [31:0] usp_q, usp_d;
  logic [63:0] md_q, md_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] vfa_q, vfa_d;
  logic [31:0] esa_q, esa_d;
  logic [31:0] asp_q, asp_d;

  // writes from software are applied first, then hardware updates,
  // so a flag event in the same cycle as a software write wins
  always_comb begin
    logic [31:0] step_sp;
    cc_d = cc_q;
    vtb_d = vtb_q;
    link_d = link_q;
    ssp_d = ssp_q;
    usp_d = usp_q;
    md_d = md_q;
    step_sp = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        // a status write that opens interrupts lands here; a re-run yields the same value
        REG_CONDITION_CODES: cc_d = reg_wdata[7:0] & CC_WRITE_MASK; // RULE_01 RULE_11
        REG_VECTOR_TABLE_BASE: vtb_d = reg_wdata;
        REG_RETURN_LINK: link_d = reg_wdata;
        REG_SYSTEM_STACK_POINTER: ssp_d = reg_wdata;
        REG_USER_STACK_POINTER: usp_d = reg_wdata;
        REG_MULDIV_HIGH_WORD: md_d[63:32] = reg_wdata;
        // dividend is placed here by software before dividing
        REG_MULDIV_LOW_WORD: md_d[31:0] = reg_wdata; // RULE_23
        REG_ACTIVE_STACK: begin
          if (cc_q[CC_STACK_SELECT]) begin // RULE_02
            usp_d = reg_wdata;
          end else begin
            ssp_d = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (flag_update.update_nz) begin
      cc_d[CC_NEGATIVE] = flag_update.result[31]; // RULE_05
      cc_d[CC_ZERO] = (flag_update.result == 32'h0000_0000); // RULE_06
    end
    if (flag_update.update_v) begin
      cc_d[CC_OVERFLOW] = flag_update.overflow; // RULE_07
    end
    // for shifts the execution unit presents the last bit shifted out as carry
    if (flag_update.update_c) begin
      cc_d[CC_CARRY] = flag_update.carry; // RULE_08 RULE_09
    end
    // single link register: a nested call simply overwrites it
    if (call_req.call) begin
      link_d = call_req.call_address +
               (call_req.delay_slot ? CALL_STEP_DELAY_SLOT : CALL_STEP_NO_SLOT); // RULE_17 RULE_18
    end
    if (event_req.take) begin
      // state is pushed below the system pointer even in user mode
      ssp_d = ssp_d - STACK_WORD - STACK_WORD; // RULE_19
    end else if (stack_req.push != stack_req.pop) begin
      step_sp = cc_q[CC_STACK_SELECT] ? usp_d : ssp_d; // RULE_02
      step_sp = stack_req.push ? step_sp - STACK_WORD : step_sp + STACK_WORD; // RULE_20
      if (cc_q[CC_STACK_SELECT]) begin
        usp_d = step_sp;
      end else begin
        ssp_d = step_sp;
      end
    end
    if (muldiv_req.load_product) begin
      md_d = muldiv_req.product; // RULE_22
    end else if (muldiv_req.load_divide) begin
      md_d = {muldiv_req.remainder, muldiv_req.quotient}; // RULE_23
    end
  end

  // derived outputs are registered alongside the state
  always_comb begin
    logic [31:0] vsum;
    vsum = vtb_q + {22'h00_0000, event_req.vector_offset}; // RULE_13
    // an out-of-range base wraps silently into low memory
    vfa_d = vsum & WORD_ALIGN_MASK; // RULE_14 RULE_16
    // pre-decremented address at which the old program counter lands
    esa_d = ssp_q - STACK_WORD; // RULE_19
    // updated address: decremented after a push, incremented after a pop
    asp_d = cc_d[CC_STACK_SELECT] ? usp_d : ssp_d; // RULE_02 RULE_20
    rdata_d = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        REG_CONDITION_CODES: rdata_d = {24'h00_0000, cc_q};
        REG_VECTOR_TABLE_BASE: rdata_d = vtb_q;
        REG_RETURN_LINK: rdata_d = link_q;
        REG_SYSTEM_STACK_POINTER: rdata_d = ssp_q;
        REG_USER_STACK_POINTER: rdata_d = usp_q;
        REG_MULDIV_HIGH_WORD: rdata_d = md_q[63:32];
        REG_MULDIV_LOW_WORD: rdata_d = md_q[31:0];
        REG_ACTIVE_STACK: rdata_d = cc_q[CC_STACK_SELECT] ? usp_q : ssp_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // undefined-at-reset registers get zero so simulation stays clean
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_q <= 8'h00; // RULE_10
      vtb_q <= VECTOR_TABLE_BASE_RESET; // RULE_15
      link_q <= 32'h0000_0000; // RULE_18
      ssp_q <= SYSTEM_STACK_POINTER_RESET; // RULE_21
      usp_q <= 32'h0000_0000;
      md_q <= 64'h0000_0000_0000_0000;
      rdata_q <= 32'h0000_0000;
      vfa_q <= 32'h0000_0000;
      esa_q <= 32'h0000_0000;
      asp_q <= 32'h0000_0000;
    end else begin
      cc_q <= cc_d;
      vtb_q <= vtb_d;
      link_q <= link_d;
      ssp_q <= ssp_d;
      usp_q <= usp_d;
      md_q <= md_d;
      rdata_q <= rdata_d;
      vfa_q <= vfa_d;
      esa_q <= esa_d;
      asp_q <= asp_d;
    end
  end

  // divide step bits live in the system condition field outside this block;
  // their early update before an event is harmless because the re-run matches (RULE_12)
  always_comb begin
    reg_rdata = rdata_q;
    condition_codes = cc_q;
    vector_fetch_address = vfa_q;
    event_save_address = esa_q;
    active_stack_pointer = asp_q;
    return_target = link_q; // RULE_17
    muldiv_result = md_q;
    interrupts_enabled = cc_q[CC_INT_ENABLE]; // RULE_04
    return_from_event_allowed = ~cc_q[CC_STACK_SELECT]; // RULE_03
  end

endmodule : special_regs

// *** test/exec_model.sv ***
// stand-in execution unit: an adder that feeds flag updates
`timescale 1ns/1ps
module exec_model
  import special_regs_pkg::*;
(
  input wire logic go,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output special_regs_pkg::flag_update_t flag_update
);
  logic [32:0] sum;
  assign sum = {1'b0, op_a} + {1'b0, op_b};
  // overflow only when like-signed operands give a sum of the other sign
  assign flag_update = '{go, go, go, sum[31:0], (op_a[31] == op_b[31]) && (sum[31] != op_a[31]),
    sum[32]};
endmodule : exec_model

// *** test/special_regs_assertions.sv ***
// port assertions for the special register set
`timescale 1ns/1ps
module special_regs_assertions
  import special_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire special_regs_pkg::flag_update_t flag_update,
  input wire special_regs_pkg::call_req_t call_req,
  input wire special_regs_pkg::event_req_t event_req,
  input wire special_regs_pkg::muldiv_req_t muldiv_req,
  input wire logic [7:0] condition_codes,
  input wire logic [31:0] vector_fetch_address,
  input wire logic [31:0] return_target,
  input wire logic [63:0] muldiv_result,
  input wire logic return_from_event_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  word_align_a: assert property (vector_fetch_address[1:0] == 2'b00)
    else $error("vector address not word aligned");
  event_gate_a: assert property (return_from_event_allowed == !condition_codes[5])
    else $error("return permission does not follow stack select");
  link_load_a: assert property (call_req.call |=> return_target == $past(call_req.call_address)
    + ($past(call_req.delay_slot) ? 32'h0000_0004 : 32'h0000_0002)) else $error("bad link value");
  neg_flag_a: assert property (flag_update.update_nz |=> condition_codes[3] == $past(flag_update.result[31]))
    else $error("negative flag wrong");
  zero_flag_a: assert property (flag_update.update_nz |=> condition_codes[2] == ($past(flag_update.result) == 32'h0))
    else $error("zero flag wrong");
  ovf_flag_a: assert property (flag_update.update_v |=> condition_codes[1] == $past(flag_update.overflow))
    else $error("overflow flag wrong");
  carry_flag_a: assert property (flag_update.update_c |=> condition_codes[0] == $past(flag_update.carry))
    else $error("carry flag wrong");
  product_load_a: assert property (muldiv_req.load_product |=> muldiv_result == $past(muldiv_req.product))
    else $error("product not stored");
  divide_load_a: assert property (muldiv_req.load_divide && !muldiv_req.load_product |=>
    muldiv_result == {$past(muldiv_req.remainder), $past(muldiv_req.quotient)}) else $error("bad divide");
  cover property (call_req.call && call_req.delay_slot);
  cover property (event_req.take);
  cover property (muldiv_req.load_divide);
endmodule : special_regs_assertions

// *** test/tb_top.sv ***
// self-checking bench for the special register set
`timescale 1ns/1ps
module tb_top;
  import special_regs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0, go = 1'b0;
  logic return_from_call = 1'b0, interrupts_enabled, return_from_event_allowed;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, op_a = '0, op_b = '0, reg_rdata, vector_fetch_address;
  logic [31:0] event_save_address, active_stack_pointer, return_target, s, u, ca;
  logic [63:0] muldiv_result, p;
  logic [7:0] condition_codes;
  flag_update_t flag_update;
  call_req_t call_req = '0;
  stack_req_t stack_req = '0;
  event_req_t event_req = '0;
  muldiv_req_t muldiv_req = '0;
  int errors = 0, cmp_count = 0;
  special_regs dut_u (.*);
  exec_model exec_u (.go(go), .op_a(op_a), .op_b(op_b), .flag_update(flag_update));
  always #4 clk = ~clk;
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(what, exp, reg_rdata);
    @(posedge clk);
  endtask : rd
  function automatic logic [63:0] flags(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] t;
    t = {1'b0, a} + {1'b0, b};
    return {t[31], t[31:0] == 32'h0, (a[31] == b[31]) && (t[31] != a[31]), t[32]};
  endfunction : flags
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #100000 errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(28216));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("select/enable", 2'b00, condition_codes[5:4]);
    @(posedge clk);
    rd(REG_VECTOR_TABLE_BASE, 32'h000f_fc00, "vtb reset");
    rd(REG_SYSTEM_STACK_POINTER, 32'h0000_0000, "ssp reset");
    wr(4'h8, $urandom);
    rd(4'h8, 32'h0000_0000, "unmapped");
    wr(REG_CONDITION_CODES, 32'h0000_00ff);
    rd(REG_CONDITION_CODES, 32'h0000_003f, "cc bits");
    chk("int enable", 1'b1, interrupts_enabled);
    $display("test registers done");
    s = $urandom & 32'hffff_fffc;
    u = $urandom & 32'hffff_fffc;
    wr(REG_SYSTEM_STACK_POINTER, s);
    wr(REG_USER_STACK_POINTER, u);
    rd(REG_ACTIVE_STACK, u, "active usp");
    stack_req <= '{1'b1, 1'b0};
    @(posedge clk);
    stack_req <= '0;
    rd(REG_USER_STACK_POINTER, u - 32'h4, "usp push");
    wr(REG_VECTOR_TABLE_BASE, 32'h8765_4123);
    event_req <= '{1'b1, 10'h3b8};
    @(posedge clk);
    event_req.take <= 1'b0;
    #1 chk("vector addr", 32'h8765_44d8, vector_fetch_address);
    @(posedge clk);
    rd(REG_SYSTEM_STACK_POINTER, s - 32'h8, "event save");
    wr(REG_CONDITION_CODES, 32'h0000_0000);
    chk("rfe allowed", 1'b1, return_from_event_allowed);
    chk("int disable", 1'b0, interrupts_enabled);
    rd(REG_ACTIVE_STACK, s - 32'h8, "active ssp");
    stack_req <= '{1'b0, 1'b1};
    @(posedge clk);
    stack_req <= '0;
    rd(REG_SYSTEM_STACK_POINTER, s - 32'h4, "ssp pop");
    chk("active pointer", s - 32'h4, active_stack_pointer);
    chk("save address", s - 32'h8, event_save_address);
    $display("test stacks done");
    for (int i = 0; i < 24; i++) begin
      op_a <= (i == 0) ? 32'h0000_0001 : (i == 1) ? 32'h8000_0000 : $urandom;
      op_b <= (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h8000_0000 : $urandom;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1 chk("nzvc", flags(op_a, op_b), condition_codes[3:0]);
      @(posedge clk);
    end
    for (int i = 0; i < 4; i++) begin
      ca = $urandom & 32'hffff_fffe;
      call_req <= '{1'b1, i[0], ca};
      @(posedge clk);
      call_req.call <= 1'b0;
      #1 chk("link", ca + (i[0] ? 32'h0000_0004 : 32'h0000_0002), return_target);
      @(posedge clk);
    end
    p = {$urandom, $urandom};
    muldiv_req <= '{1'b1, p, 1'b0, 32'h0000_0000, 32'h0000_0000};
    @(posedge clk);
    muldiv_req.load_product <= 1'b0;
    rd(REG_MULDIV_HIGH_WORD, p[63:32], "product high");
    rd(REG_MULDIV_LOW_WORD, p[31:0], "product low");
    wr(REG_MULDIV_LOW_WORD, $urandom);
    muldiv_req <= '{1'b0, 64'h0, 1'b1, p[31:0], p[63:32]};
    @(posedge clk);
    muldiv_req.load_divide <= 1'b0;
    rd(REG_MULDIV_HIGH_WORD, p[31:0], "remainder");
    rd(REG_MULDIV_LOW_WORD, p[63:32], "quotient");
    $display("test flags, calls and muldiv done");
    end_of_test();
  end
endmodule : tb_top
bind special_regs special_regs_assertions chk_u (.clk, .rst_b, .flag_update, .call_req,
  .event_req, .muldiv_req, .condition_codes, .vector_fetch_address, .return_target,
  .muldiv_result, .return_from_event_allowed);
